// ---- smbus_pkg.sv ----
// shared constants and types for the two-wire management bus ends
package smbus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 100_000;
  // quarter of a serial clock period, in ref_clk cycles
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int QTR_W = 8;
  // bus lockup timeout
  localparam int TIMEOUT_MS = 35;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TO_W = 22;

  ////////////////////////////////////////////////////////////////////////////
  // slave addresses chosen by the straps
  localparam logic [6:0] ADDR_FIXED = 7'h2e;
  localparam logic [6:0] ADDR_SEL0 = 7'h2c;
  localparam logic [6:0] ADDR_SEL1 = 7'h2d;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_END = 4'h9;
  localparam logic [1:0] MAX_WR_BYTES = 2'h2;
  // configuration register that holds the timeout disable bit
  localparam logic [7:0] CFG1_PTR = 8'h40;
  localparam int TDIS_BIT = 6;
  localparam logic TDIS_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // device states, gray along idle-addr-write-read-ignore
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_WRITE = 3'h3,
    DS_READ = 3'h2,
    DS_IGNORE = 3'h6
  } dev_st_e;

  // master states, gray along idle-start-bit-stop
  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_START = 2'h1,
    MS_BIT = 2'h3,
    MS_STOP = 2'h2
  } mst_st_e;

  // master commands
  typedef enum logic [1:0] {
    CMD_SEND = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_RECV = 2'h2,
    CMD_READ = 2'h3
  } cmd_e;

  // steps of a master command
  typedef enum logic [2:0] {
    A_ADDR_W = 3'h0,
    A_ADDR_R = 3'h1,
    A_PTR = 3'h2,
    A_DATA = 3'h3,
    A_RDBYTE = 3'h4,
    A_RSTART = 3'h5,
    A_STOP = 3'h6
  } act_e;

endpackage

// ---- smbus_if.sv ----
// open-drain two-wire bus joining the master end and the device end
`timescale 1ns/10ps
interface smbus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // pull-ups: a line is high unless some enabled driver pulls it
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport device (
    output d_sda_o,
    output d_sda_oe,
    input scl,
    input sda
  );
endinterface

// ---- sync2.sv ----
// two flip-flop synchroniser for levels entering the ref_clk domain
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input logic clk,
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s q;
  sync_s d;

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_comb begin
    d.meta = din;
    d.sync = q.meta;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.sync;
endmodule

// ---- smbus_device.sv ----
// device end: bus slave with address straps, pointer and timeout
// Notes on behaviour
// - strap enable high selects fixed address
// - strap enable low: select pin picks address
// - straps follow until first match, then frozen
// - start is sda falling, scl high; eight bits
// - matched address acknowledged; mismatch ignored until stop or start
// - direction bit zero writes, one reads
// - nine pulses per byte; sda moves scl low
// - sda rising with scl high is stop
// - master ends read with nack then stop
// - direction fixed until next start
// - writes one or two bytes; reads one
// - first written byte loads register pointer
// - second written byte stored at pointer
// - read returns pointed register, pointer kept
// - repeated start opens a new address phase
// - send, receive and read byte supported
// - 35 ms idle open transaction releases bus
// - config 0x40 bit 6 disables timeout
`timescale 1ns/10ps
module smbus_device
  import smbus_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input logic ref_clk,
  input logic nrst,
  smbus_if.device bus,
  input logic address_strap_enable,
  input logic addr_select,
  output logic [7:0] rd_addr,
  input logic [7:0] rd_data,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic bus_timeout_disable,
  output logic addr_locked
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shifts sda in on every rising scl
  typedef struct packed {
    logic [7:0] rx;
  } link_s;

  link_s lq;
  link_s ld;

  always_comb begin
    ld.rx = {lq.rx[6:0], bus.sda};
  end

  always_ff @(posedge bus.scl) begin
    lq <= ld;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins brought into the ref_clk domain
  logic scl_s;
  logic sda_s;
  logic strap_en_s;
  logic strap_sel_s;

  sync2 #(
    .W(4)
  ) u_pin_sync (
    .clk(ref_clk),
    .din({bus.scl, bus.sda, address_strap_enable, addr_select}),
    .dout({scl_s, sda_s, strap_en_s, strap_sel_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap decode
  function automatic logic [6:0] strap_addr(input logic en,
                                            input logic sel);
    if (en) begin
      strap_addr = ADDR_FIXED;
    end else if (sel) begin
      strap_addr = ADDR_SEL1;
    end else begin
      strap_addr = ADDR_SEL0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ref_clk domain state
  typedef struct packed {
    dev_st_e st;
    logic [3:0] bit_cnt;
    logic [1:0] nbytes;
    logic ack_ok;
    logic rnw;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] hold;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic tdis;
    logic locked;
    logic [6:0] addr;
    logic scl_p;
    logic sda_p;
    logic [TO_W-1:0] to_cnt;
  } dev_s;

  dev_s q;
  dev_s d;

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic active;
  logic to_hit;
  logic busy;

  // bus conditions seen on the synchronised lines
  assign rise = scl_s & ~q.scl_p;
  assign fall = ~scl_s & q.scl_p;
  assign start = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop = scl_s & q.scl_p & ~q.sda_p & sda_s;
  assign active = (scl_s ^ q.scl_p) | (sda_s ^ q.sda_p);
  assign busy = (q.st != DS_IDLE) && (q.st != DS_IGNORE);
  assign to_hit = (q.st != DS_IDLE) && !q.tdis &&
                  (q.to_cnt == TO_W'(TIMEOUT_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_comb begin
    d = q;
    d.wr_en = 1'b0;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    // address follows the straps until the first match freezes it
    if (!q.locked) begin
      d.addr = strap_addr(strap_en_s, strap_sel_s);
    end
    // read byte is frozen once a read has been addressed
    if (q.st != DS_READ && !(q.st == DS_ADDR && q.bit_cnt >= ACK_SLOT)) begin
      d.hold = rd_data;
    end
    // inactivity counter for an open transaction
    if (q.st == DS_IDLE || active) begin
      d.to_cnt = '0;
    end else begin
      d.to_cnt = q.to_cnt + 1'b1;
    end
    if (start) begin
      // a start or repeated start always opens an address phase
      d.st = DS_ADDR;
      d.bit_cnt = 4'h0;
      d.nbytes = 2'h0;
      d.ack_ok = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop || to_hit) begin
      d.st = DS_IDLE;
      d.sda_oe = 1'b0;
      d.to_cnt = '0;
    end else if (rise && busy) begin
      d.bit_cnt = q.bit_cnt + 4'h1;
      if (q.bit_cnt == LAST_DATA_BIT) begin
        case (q.st)
          DS_ADDR: begin
            if (lq.rx[7:1] == q.addr) begin
              d.locked = 1'b1;
              d.rnw = lq.rx[0];
              d.ack_ok = 1'b1;
            end else begin
              d.st = DS_IGNORE;
            end
          end
          DS_WRITE: begin
            d.ack_ok = q.nbytes < MAX_WR_BYTES;
            if (q.nbytes != 2'h3) begin
              d.nbytes = q.nbytes + 2'h1;
            end
            if (q.nbytes == 2'h0) begin
              d.ptr = lq.rx;
            end else if (q.nbytes == 2'h1) begin
              d.wr_en = 1'b1;
              d.wr_addr = q.ptr;
              d.wr_data = lq.rx;
              if (q.ptr == CFG1_PTR) begin
                d.tdis = lq.rx[TDIS_BIT];
              end
            end
          end
          default: begin
          end
        endcase
      end
      // a read returns one byte, then waits for stop or start
      if (q.st == DS_READ && q.bit_cnt == ACK_SLOT) begin
        d.st = DS_IGNORE;
      end
    end else if (fall && busy) begin
      case (q.bit_cnt)
        ACK_SLOT: begin
          d.sda_oe = (q.st != DS_READ) && q.ack_ok;
        end
        BYTE_END: begin
          d.bit_cnt = 4'h0;
          d.sda_oe = 1'b0;
          if (q.st == DS_ADDR) begin
            d.st = q.rnw ? DS_READ : DS_WRITE;
            d.sda_oe = q.rnw & ~q.hold[7];
          end
        end
        default: begin
          if (q.st == DS_READ) begin
            d.sda_oe = ~q.hold[3'h7 - q.bit_cnt[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
      q.tdis <= TDIS_RESET;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = q.sda_oe;
  assign rd_addr = q.ptr;
  assign wr_en = q.wr_en;
  assign wr_addr = q.wr_addr;
  assign wr_data = q.wr_data;
  assign bus_timeout_disable = q.tdis;
  assign addr_locked = q.locked;
endmodule

// ---- smbus_master.sv ----
// master end: serial clock divider and command sequencer
`timescale 1ns/10ps
module smbus_master
  import smbus_pkg::*;
(
  input logic ref_clk,
  input logic nrst,
  smbus_if.master bus,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic [1:0] cmd_kind,
  input logic [6:0] cmd_dev_addr,
  input logic [7:0] cmd_ptr,
  input logic [7:0] cmd_data,
  output logic done,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  ////////////////////////////////////////////////////////////////////////////
  // sequence of steps for each command
  function automatic act_e act_of(input cmd_e k, input logic [2:0] s);
    act_of = A_STOP;
    case (k)
      CMD_SEND: begin
        if (s == 3'h0) act_of = A_ADDR_W;
        else if (s == 3'h1) act_of = A_PTR;
      end
      CMD_WRITE: begin
        if (s == 3'h0) act_of = A_ADDR_W;
        else if (s == 3'h1) act_of = A_PTR;
        else if (s == 3'h2) act_of = A_DATA;
      end
      CMD_RECV: begin
        if (s == 3'h0) act_of = A_ADDR_R;
        else if (s == 3'h1) act_of = A_RDBYTE;
      end
      default: begin
        if (s == 3'h0) act_of = A_ADDR_W;
        else if (s == 3'h1) act_of = A_PTR;
        else if (s == 3'h2) act_of = A_RSTART;
        else if (s == 3'h3) act_of = A_ADDR_R;
        else if (s == 3'h4) act_of = A_RDBYTE;
      end
    endcase
  endfunction

  // sda enable for bit k of a byte; reads always end with a nack
  function automatic logic bit_oe(input logic rd, input logic [7:0] b,
                                  input logic [3:0] k);
    if (rd || k >= ACK_SLOT) begin
      bit_oe = 1'b0;
    end else begin
      bit_oe = ~b[3'h7 - k[2:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    mst_st_e st;
    logic [QTR_W-1:0] cnt;
    logic [1:0] ph;
    logic [3:0] bit_cnt;
    logic [2:0] step;
    cmd_e kind;
    logic [6:0] addr;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] sh;
    logic rd;
    logic [7:0] rx;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic done;
  } mst_s;

  mst_s q;
  mst_s d;
  logic sda_s;
  logic tick;

  sync2 #(
    .W(1)
  ) u_sda_sync (
    .clk(ref_clk),
    .din(bus.sda),
    .dout(sda_s)
  );

  assign tick = q.cnt == QTR_W'(QTR_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: four quarter phases per serial clock
  always_comb begin
    act_e a;
    a = act_of(q.kind, q.step);
    d = q;
    d.done = 1'b0;
    d.cnt = tick ? '0 : q.cnt + 1'b1;
    if (tick) begin
      d.ph = q.ph + 2'h1;
    end
    case (q.st)
      MS_IDLE: begin
        d.cnt = '0;
        d.ph = 2'h0;
        if (cmd_valid) begin
          d.st = MS_START;
          d.ready = 1'b0;
          d.kind = cmd_e'(cmd_kind);
          d.addr = cmd_dev_addr;
          d.ptr = cmd_ptr;
          d.data = cmd_data;
          d.step = 3'h0;
          d.nack = 1'b0;
        end
      end
      MS_START: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.scl_oe = 1'b0;
            2'h1: d.sda_oe = 1'b1;
            2'h2: d.scl_oe = 1'b1;
            default: begin
              d.st = MS_BIT;
              d.bit_cnt = 4'h0;
              d.rd = a == A_RDBYTE;
              d.sh = (a == A_ADDR_R) ? {q.addr, 1'b1} : {q.addr, 1'b0};
              d.sda_oe = bit_oe(d.rd, d.sh, 4'h0);
            end
          endcase
        end
      end
      MS_BIT: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.scl_oe = 1'b0;
            2'h1: begin
              if (q.bit_cnt < ACK_SLOT) begin
                d.rx = {q.rx[6:0], sda_s};
              end else if (!q.rd) begin
                d.nack = sda_s;
              end
            end
            2'h2: d.scl_oe = 1'b1;
            default: begin
              d.bit_cnt = q.bit_cnt + 4'h1;
              d.sda_oe = bit_oe(q.rd, q.sh, q.bit_cnt + 4'h1);
              if (q.bit_cnt == ACK_SLOT) begin
                d.step = q.step + 3'h1;
                a = act_of(q.kind, q.step + 3'h1);
                d.bit_cnt = 4'h0;
                d.rd = a == A_RDBYTE;
                d.sh = (a == A_PTR) ? q.ptr :
                       (a == A_DATA) ? q.data : q.sh;
                d.sda_oe = bit_oe(d.rd, d.sh, 4'h0);
                if (q.nack || a == A_STOP) begin
                  d.st = MS_STOP;
                  d.sda_oe = 1'b1;
                end else if (a == A_RSTART) begin
                  d.st = MS_START;
                  d.step = q.step + 3'h2;
                  d.sda_oe = 1'b0;
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.scl_oe = 1'b0;
            2'h1: d.sda_oe = 1'b0;
            2'h2: begin
            end
            default: begin
              d.st = MS_IDLE;
              d.done = 1'b1;
              d.ready = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_oe = q.sda_oe;
  assign cmd_ready = q.ready;
  assign done = q.done;
  assign rsp_data = q.rx;
  assign rsp_nack = q.nack;
endmodule

// ---- smbus_monitor.sv ----
// protocol checker for the bus between the master end and the device end
`timescale 1ns/10ps
module smbus_monitor #(
  parameter logic [6:0] DEV_ADDR = 7'h2d
) (
  input logic ref_clk,
  input logic nrst,
  input logic scl,
  input logic sda,
  input logic m_sda_oe,
  input logic d_sda_oe
);
  localparam int LO_MIN = 480;
  localparam int LO_MAX = 520;
  logic scl_p;
  logic sda_p;
  logic first_q;
  logic ign_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [10:0] lo_q;
  logic start;
  logic rise;

  ////////////////////////////////////////////////////////////////////////////
  // start detect, bit framing and scl low-phase length
  assign start = scl & scl_p & sda_p & ~sda;
  assign rise = scl & ~scl_p;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      first_q <= 1'b0;
      ign_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      lo_q <= 11'h000;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      lo_q <= scl ? 11'h000 : lo_q + {10'h000, lo_q != 11'h7ff};
      if (start) begin
        cnt_q <= 4'h0;
        first_q <= 1'b1;
        ign_q <= 1'b0;
      end else if (rise && cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        first_q <= 1'b0;
        ign_q <= ign_q | (first_q & (sh_q[7:1] != DEV_ADDR));
      end else if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions, all in the ref_clk domain
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_dev_steady;
    scl && $past(scl) |-> $stable(d_sda_oe);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("device moved sda while scl high");
  property p_mst_steady;
    $rose(scl) |-> ##1 $stable(m_sda_oe) [*8];
  endproperty
  a_mst_steady: assert property (p_mst_steady)
    else $error("master moved sda just after scl rose");
  property p_scl_low;
    $rose(scl) |-> lo_q inside {[LO_MIN:LO_MAX]};
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase length off");
  property p_drive_low;
    $rose(d_sda_oe) |-> !scl && lo_q inside {[1:8]};
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("device took sda outside a fresh scl low phase");
  property p_release_low;
    $fell(d_sda_oe) |-> !scl && lo_q inside {[1:8]};
  endproperty
  a_release_low: assert property (p_release_low)
    else $error("device released sda outside a fresh scl low phase");
  property p_ack_hold;
    $rose(d_sda_oe) |-> d_sda_oe throughout (##[1:600] $rose(scl));
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device drive not held up to the next scl rise");
  property p_addr_ack;
    rise && first_q && cnt_q == 4'h8 |-> sda == (sh_q[7:1] != DEV_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge does not follow the match");
  property p_ign_quiet;
    ign_q |-> !d_sda_oe;
  endproperty
  a_ign_quiet: assert property (p_ign_quiet)
    else $error("device drove sda after a foreign address");
  property p_start_master;
    start |-> m_sda_oe && !d_sda_oe;
  endproperty
  a_start_master: assert property (p_start_master)
    else $error("start condition not made by the master");
endmodule

// ---- smbus_slave_register_access_tb.sv ----
// self-checking bench: master end and device end joined by the bus
`timescale 1ns/10ps
module smbus_slave_register_access_tb;
  import smbus_pkg::*;
  localparam int TO_CYC = 2000;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [6:0] cmd_dev_addr = 7'h00;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic strap_en = 1'b0;
  logic strap_sel = 1'b1;
  logic strap_en_b = 1'b1;
  logic strap_sel_b = 1'b0;
  logic [7:0] rd_data_b = 8'h00;
  logic cmd_ready;
  logic done;
  logic rsp_nack;
  logic [7:0] rsp_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic tdis;
  logic locked;
  logic tdis_b;
  logic locked_b;
  int wr_count = 0;
  int bad_count = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // bus a: both design ends; bus b: device end against bench bit-banging
  smbus_if bus_a();
  smbus_if bus_b();
  smbus_master u_smbus_master (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus_a),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_dev_addr(cmd_dev_addr), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .done(done), .rsp_data(rsp_data), .rsp_nack(rsp_nack)
  );
  smbus_device #(.TIMEOUT_CYCLES(TO_CYC)) u_smbus_device (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus_a),
    .address_strap_enable(strap_en), .addr_select(strap_sel),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data),
    .bus_timeout_disable(tdis), .addr_locked(locked)
  );
  smbus_device #(.TIMEOUT_CYCLES(TO_CYC)) u_smbus_device_b (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus_b),
    .address_strap_enable(strap_en_b), .addr_select(strap_sel_b),
    .rd_addr(), .rd_data(rd_data_b), .wr_en(), .wr_addr(), .wr_data(),
    .bus_timeout_disable(tdis_b), .addr_locked(locked_b)
  );
  smbus_monitor #(.DEV_ADDR(7'h2d)) u_smbus_monitor (
    .ref_clk(ref_clk), .nrst(nrst), .scl(bus_a.scl), .sda(bus_a.sda),
    .m_sda_oe(bus_a.m_sda_oe), .d_sda_oe(bus_a.d_sda_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, register file answer and write counter
  always #5 ref_clk = ~ref_clk;
  assign rd_data = rd_addr ^ 8'ha5;
  always @(posedge ref_clk) begin
    if (wr_en === 1'b1) begin
      wr_count <= wr_count + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and command tasks
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic [1:0] k, input logic [6:0] a,
                         input logic [7:0] p, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    cmd_kind = k;
    cmd_dev_addr = a;
    cmd_ptr = p;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    check("busy", {7'h00, cmd_ready}, 8'h00);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    check("done", {7'h00, done}, 8'h01);
  endtask

  // bench bit-banging on bus b, ten cycles a quarter
  task automatic qwait();
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic b_start();
    bus_b.m_sda_oe = 1'b0;
    bus_b.m_scl_oe = 1'b0;
    qwait();
    bus_b.m_sda_oe = 1'b1;
    qwait();
    bus_b.m_scl_oe = 1'b1;
    qwait();
  endtask

  task automatic b_bit(input logic b, output logic s);
    bus_b.m_sda_oe = ~b;
    qwait();
    bus_b.m_scl_oe = 1'b0;
    qwait();
    s = bus_b.sda;
    qwait();
    bus_b.m_scl_oe = 1'b1;
    qwait();
  endtask

  task automatic b_byte(input logic [7:0] v, output logic ack);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      b_bit(v[i], t);
    end
    b_bit(1'b1, ack);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic ack;
    bus_b.m_scl_o = 1'b0;
    bus_b.m_sda_o = 1'b0;
    bus_b.m_scl_oe = 1'b0;
    bus_b.m_sda_oe = 1'b0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    check("ready", {7'h00, cmd_ready}, 8'h01);
    check("pointer", rd_addr, 8'h00);
    check("locked", {7'h00, locked}, 8'h00);
    check("tdis", {7'h00, tdis}, 8'h00);
    // bus b: foreign address, fixed-strap read, then a stalled bus
    b_start();
    b_byte({7'h2c, 1'b0}, ack);
    check("b addr ack", {7'h00, ack}, 8'h01);
    b_byte(8'h00, ack);
    check("b data ack", {7'h00, ack}, 8'h01);
    b_start();
    b_byte({7'h2e, 1'b1}, ack);
    check("b read ack", {7'h00, ack}, 8'h00);
    check("b locked", {7'h00, locked_b}, 8'h01);
    repeat (20) @(negedge ref_clk);
    check("b msb", {7'h00, bus_b.sda}, 8'h00);
    repeat (TO_CYC + 100) @(negedge ref_clk);
    check("b release", {7'h00, bus_b.sda}, 8'h01);
    check("b tdis", {7'h00, tdis_b}, 8'h00);
    // bus a: write byte to the config pointer with bit 6 set
    run_cmd(CMD_WRITE, 7'h2d, CFG1_PTR, 8'h40);
    check("wr nack", {7'h00, rsp_nack}, 8'h00);
    check("locked", {7'h00, locked}, 8'h01);
    check("pointer", rd_addr, CFG1_PTR);
    check("writes", 8'(wr_count), 8'h01);
    check("wr addr", wr_addr, CFG1_PTR);
    check("wr data", wr_data, 8'h40);
    check("tdis", {7'h00, tdis}, 8'h01);
    // straps now point elsewhere; the latched address must hold
    strap_en = 1'b1;
    strap_sel = 1'b0;
    run_cmd(CMD_RECV, 7'h2d, 8'h00, 8'h00);
    check("recv nack", {7'h00, rsp_nack}, 8'h00);
    check("recv data", rsp_data, CFG1_PTR ^ 8'ha5);
    check("pointer", rd_addr, CFG1_PTR);
    run_cmd(CMD_READ, 7'h2d, 8'h81, 8'h00);
    check("read nack", {7'h00, rsp_nack}, 8'h00);
    check("read data", rsp_data, 8'h81 ^ 8'ha5);
    check("writes", 8'(wr_count), 8'h01);
    run_cmd(CMD_SEND, 7'h2e, 8'h33, 8'h00);
    check("send nack", {7'h00, rsp_nack}, 8'h01);
    check("pointer", rd_addr, 8'h81);
    // power-up again in mid-run: bus b straps pick the select-low address
    nrst = 1'b0;
    strap_en_b = 1'b0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    check("locked", {7'h00, locked}, 8'h00);
    check("tdis", {7'h00, tdis}, 8'h00);
    check("b locked", {7'h00, locked_b}, 8'h00);
    b_start();
    b_byte({7'h2c, 1'b0}, ack);
    check("b sel0 ack", {7'h00, ack}, 8'h00);
    check("b locked", {7'h00, locked_b}, 8'h01);
    give_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (140000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
endmodule
